// File: core/pms_core.sv
// phy management serial controller: registers, poller and frame engine
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module pms_core
	import pms_pkg::*;
#(
	parameter int          MDC_HALF = MDC_HALF_CYC,
	parameter logic [31:0] REV      = REV_VALUE
) (
	input  wire logic        clk,      // system clock
	input  wire logic        nrst,     // synchronous reset, active low
	input  wire logic [31:0] addr,     // register byte address
	input  wire logic [31:0] wdata,    // write data
	input  wire logic        wr,       // write strobe
	input  wire logic        rd,       // read strobe
	output logic      [31:0] rdata,    // read data, cycle after rd
	input  wire logic        linkClk,  // link side clock
	output logic             mdc,      // management clock pin
	input  wire logic        mdioIn,   // data pin level
	output logic             mdioOut,  // data pin drive value
	output logic             mdioOeN,  // data pin enable, low drives
	output logic             linkIrq,  // masked link change flag
	output logic             userIrq   // masked completion flag
);
	if (MDC_HALF < 2 || MDC_HALF > 256) begin : gBadHalf
		$error("MDC_HALF must be 2 to 256 for the pin synchroniser");
	end
	localparam logic [7:0] HALF_M1 = 8'(MDC_HALF - 1);

	////////////////////////////////////////////////////////////////////////
	// system domain state
	logic        en_reg;
	logic        txGo_reg;
	logic        txWr_reg;
	logic        txAck_reg;
	logic [4:0]  txReg_reg;
	logic [4:0]  txPhy_reg;
	logic [15:0] txData_reg;
	logic [4:0]  selPhy_reg;
	logic        selEn_reg;
	logic [31:0] alive_reg;
	logic [31:0] link_reg;
	logic        linkRaw_reg;
	logic        userRaw_reg;
	logic        userMask_reg;
	logic        reqTgl_reg;
	logic [31:0] rdata_reg;
	logic        resS1_reg;
	logic        resS2_reg;
	logic        resS3_reg;

	// link domain state
	logic        rstS1_reg;
	logic        rstS2_reg;
	logic        mdioS1_reg;
	logic        mdioS2_reg;
	logic        reqS1_reg;
	logic        reqS2_reg;
	logic        reqSeen_reg;
	logic        enS1_reg;
	logic        enS2_reg;
	pms_lstate_t lState_reg;
	logic [7:0]  divCnt_reg;
	logic        mdc_reg;
	logic [5:0]  bitCnt_reg;
	logic [63:0] shift_reg;
	logic [15:0] rx_reg;
	logic        ack_reg;
	logic        lUser_reg;
	logic        lWr_reg;
	logic [4:0]  lAddr_reg;
	logic [4:0]  pollAddr_reg;
	logic        resTgl_reg;
	logic        resUser_reg;
	logic        resAck_reg;
	logic [4:0]  resAddr_reg;
	logic [15:0] resData_reg;

	////////////////////////////////////////////////////////////////////////
	// register decode
	wire hitRev   = addr == OFF_REV;
	wire hitCtl   = addr == OFF_CTL;
	wire hitAlive = addr == OFF_ALIVE;
	wire hitLink  = addr == OFF_LINK;
	wire hitLRaw  = addr == OFF_LRAW;
	wire hitLMsk  = addr == OFF_LMSK;
	wire hitURaw  = addr == OFF_URAW;
	wire hitUMsk  = addr == OFF_UMSK;
	wire hitMSet  = addr == OFF_MSET;
	wire hitMClr  = addr == OFF_MCLR;
	wire hitTxn   = addr == OFF_TXN;
	wire hitSel   = addr == OFF_SEL;

	// completion events back from the link side
	wire resEv    = resS2_reg ^ resS3_reg;
	wire userDone = resEv & resUser_reg;
	wire pollDone = resEv & ~resUser_reg;
	wire linkNew  = resAck_reg & resData_reg[LINK_BIT];
	wire selHit   = selEn_reg && resAddr_reg == selPhy_reg;
	wire linkChg  = linkNew != link_reg[resAddr_reg];

	// only the first-mac bit of each flag register is live
	wire linkSet  = pollDone & selHit & linkChg;
	wire linkClr  = wr & (hitLRaw | hitLMsk) & wdata[MAC0];
	wire userClr  = wr & (hitURaw | hitUMsk) & wdata[MAC0];
	wire linkMsk  = linkRaw_reg & selEn_reg;
	wire userMsk  = userRaw_reg & userMask_reg;
	// set beats clear in the same cycle
	wire linkRaw_next = linkSet | (linkRaw_reg & ~linkClr);
	wire userRaw_next = userDone | (userRaw_reg & ~userClr);
	wire userMask_next = (wr & hitMSet & wdata[MAC0])
		| (userMask_reg & ~(wr & hitMClr & wdata[MAC0]));
	// writes while pending are ignored so the link sees stable fields
	wire txStart  = wr & hitTxn & wdata[TX_GO] & ~txGo_reg;
	wire txLoad   = wr & hitTxn & ~txGo_reg;

	// second-mac bits and spare registers read as zero
	wire [31:0] txnWord = {txGo_reg, txWr_reg, txAck_reg, 3'h0, txReg_reg,
		txPhy_reg, txData_reg};
	wire [31:0] ctlWord = {~txGo_reg, en_reg, 30'h0};
	wire [31:0] selWord = {25'h0, selEn_reg, 1'h0, selPhy_reg};
	wire [31:0] rdNext =
		hitRev   ? REV :
		hitCtl   ? ctlWord :
		hitAlive ? alive_reg :
		hitLink  ? link_reg :
		hitLRaw  ? {31'h0, linkRaw_reg} :
		hitLMsk  ? {31'h0, linkMsk} :
		hitURaw  ? {31'h0, userRaw_reg} :
		hitUMsk  ? {31'h0, userMsk} :
		(hitMSet | hitMClr) ? {31'h0, userMask_reg} :
		hitTxn   ? txnWord :
		hitSel   ? selWord :
		32'h0;

	assign rdata   = rdata_reg;
	assign linkIrq = linkMsk;
	assign userIrq = userMsk;

	////////////////////////////////////////////////////////////////////////
	// system domain registers
	always_ff @(posedge clk) begin
		resS1_reg <= resTgl_reg;
		resS2_reg <= resS1_reg;
		if (!nrst) begin
			resS3_reg <= 1'h0;
			rdata_reg <= 32'h0;
			linkRaw_reg <= 1'h0;
			userRaw_reg <= 1'h0;
			userMask_reg <= MASK_RST;
		end else begin
			resS3_reg <= resS2_reg;
			rdata_reg <= rd ? rdNext : 32'h0;
			linkRaw_reg <= linkRaw_next;
			userRaw_reg <= userRaw_next;
			userMask_reg <= userMask_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			en_reg <= EN_RST;
			selPhy_reg <= SEL_RST;
			selEn_reg <= 1'h0;
		end else if (wr && hitCtl) begin
			en_reg <= wdata[CTL_EN];
		end else if (wr && hitSel) begin
			selPhy_reg <= wdata[4:0];
			selEn_reg <= wdata[SEL_LINKEN];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			txGo_reg <= 1'h0;
			txWr_reg <= 1'h0;
			txAck_reg <= 1'h0;
			txReg_reg <= 5'h0;
			txPhy_reg <= 5'h0;
			txData_reg <= 16'h0;
			reqTgl_reg <= 1'h0;
		end else if (txLoad) begin
			txGo_reg <= wdata[TX_GO];
			txWr_reg <= wdata[TX_WR];
			txReg_reg <= wdata[TX_REG_LSB +: 5];
			txPhy_reg <= wdata[TX_PHY_LSB +: 5];
			txData_reg <= wdata[15:0];
			reqTgl_reg <= reqTgl_reg ^ txStart;
		end else if (userDone) begin
			txGo_reg <= 1'h0;
			txAck_reg <= resAck_reg;
			if (!txWr_reg)
				txData_reg <= resData_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			alive_reg <= 32'h0;
			link_reg <= 32'h0;
		end else if (pollDone) begin
			alive_reg[resAddr_reg] <= resAck_reg;
			link_reg[resAddr_reg] <= linkNew;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link domain: synchronisers, no reset on any stage
	always_ff @(posedge linkClk) begin
		rstS1_reg <= nrst;
		rstS2_reg <= rstS1_reg;
		mdioS1_reg <= mdioIn;
		mdioS2_reg <= mdioS1_reg;
		reqS1_reg <= reqTgl_reg;
		reqS2_reg <= reqS1_reg;
		enS1_reg <= en_reg;
		enS2_reg <= enS1_reg;
	end

	// software commands take precedence over the background poll
	wire tick    = divCnt_reg == HALF_M1;
	wire newReq  = reqS2_reg != reqSeen_reg;
	wire lStart  = lState_reg == L_IDLE && tick && (newReq || enS2_reg);
	wire fall    = lState_reg == L_SHIFT && tick && mdc_reg;
	wire lLast   = fall && bitCnt_reg == LAST_BIT;
	wire fWr     = newReq & txWr_reg;
	wire [4:0] fPhy = newReq ? txPhy_reg : pollAddr_reg;
	wire [4:0] fReg = newReq ? txReg_reg : POLL_REG;
	wire [63:0] frame = {32'hffffffff, 2'h1, fWr ? 2'h1 : 2'h2,
		fPhy, fReg, fWr ? 2'h2 : 2'h3, fWr ? txData_reg : 16'hffff};
	// release the pin from the turnaround on in a read
	wire drive   = lState_reg == L_SHIFT
		&& !(!lWr_reg && bitCnt_reg >= TA_BIT);

	assign mdc     = mdc_reg;
	assign mdioOut = shift_reg[63];
	assign mdioOeN = ~drive;

	always_ff @(posedge linkClk) begin
		if (!rstS2_reg)
			divCnt_reg <= 8'h0;
		else
			divCnt_reg <= tick ? 8'h0 : divCnt_reg + 8'h1;
	end

	// data changes on the falling edge, phy samples on the rising one
	always_ff @(posedge linkClk) begin
		if (!rstS2_reg) begin
			lState_reg <= L_IDLE;
			mdc_reg <= 1'h0;
			bitCnt_reg <= 6'h0;
			shift_reg <= 64'h0;
			lUser_reg <= 1'h0;
			lWr_reg <= 1'h0;
			lAddr_reg <= 5'h0;
			reqSeen_reg <= 1'h0;
		end else if (lStart) begin
			lState_reg <= L_SHIFT;
			shift_reg <= frame;
			bitCnt_reg <= 6'h0;
			lUser_reg <= newReq;
			lWr_reg <= fWr;
			lAddr_reg <= fPhy;
			reqSeen_reg <= reqS2_reg;
		end else if (lState_reg == L_SHIFT && tick) begin
			mdc_reg <= ~mdc_reg;
			if (mdc_reg) begin
				shift_reg <= {shift_reg[62:0], 1'h1};
				bitCnt_reg <= bitCnt_reg + 6'h1;
				if (lLast)
					lState_reg <= L_IDLE;
			end
		end
	end

	// sample just before mdc falls; the pin synchroniser needs MDC_HALF >= 2
	always_ff @(posedge linkClk) begin
		if (!rstS2_reg) begin
			rx_reg <= 16'h0;
			ack_reg <= 1'h0;
			pollAddr_reg <= 5'h0;
			resTgl_reg <= 1'h0;
			resUser_reg <= 1'h0;
			resAck_reg <= 1'h0;
			resAddr_reg <= 5'h0;
			resData_reg <= 16'h0;
		end else if (fall) begin
			if (bitCnt_reg == ACK_BIT)
				ack_reg <= ~mdioS2_reg;
			if (bitCnt_reg >= DATA_BIT)
				rx_reg <= {rx_reg[14:0], mdioS2_reg};
			if (lLast) begin
				resTgl_reg <= ~resTgl_reg;
				resUser_reg <= lUser_reg;
				resAck_reg <= ack_reg | lWr_reg;
				resAddr_reg <= lAddr_reg;
				resData_reg <= {rx_reg[14:0], mdioS2_reg};
				if (!lUser_reg)
					pollAddr_reg <= pollAddr_reg + 5'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence sUserDone;
		resEv && resUser_reg;
	endsequence

	a_done_clears_go: assert property (@(posedge clk) disable iff (!nrst)
		sUserDone |=> !txGo_reg && userRaw_reg)
		else $error("completion did not clear pending");

	a_start_pending: assert property (@(posedge clk) disable iff (!nrst)
		txStart |=> txGo_reg && reqTgl_reg != $past(reqTgl_reg))
		else $error("start did not raise pending");

	a_alive_update: assert property (@(posedge clk) disable iff (!nrst)
		pollDone |=> alive_reg[$past(resAddr_reg)] == $past(resAck_reg))
		else $error("presence not recorded");

	a_link_state: assert property (@(posedge clk) disable iff (!nrst)
		pollDone |=> link_reg[$past(resAddr_reg)] == $past(linkNew))
		else $error("link state not recorded");

	a_link_change: assert property (@(posedge clk) disable iff (!nrst)
		linkSet |=> linkRaw_reg && (linkIrq == selEn_reg))
		else $error("link change flag missing");

	a_mask_gate: assert property (@(posedge clk) disable iff (!nrst)
		wr && hitMSet && wdata[MAC0] && userRaw_reg && !userClr |=> userIrq)
		else $error("mask set did not pass flag");

	a_second_mac_zero: assert property (@(posedge clk) disable iff (!nrst)
		rd && (hitLRaw || hitURaw) |=> rdata[SECOND_MAC] == 1'h0)
		else $error("second mac bit active");

	a_sel_write: assert property (@(posedge clk) disable iff (!nrst)
		wr && hitSel |=> selPhy_reg == $past(wdata[4:0]))
		else $error("select not written");

	a_poll_step: assert property (@(posedge linkClk) disable iff (!rstS2_reg)
		lLast && !lUser_reg |=> pollAddr_reg == $past(pollAddr_reg) + 5'h1)
		else $error("poll address did not advance");

	a_ta_release: assert property (@(posedge linkClk) disable iff (!rstS2_reg)
		lState_reg == L_SHIFT && !lWr_reg && bitCnt_reg >= TA_BIT |-> mdioOeN)
		else $error("read turnaround still driven");

	a_frame_start: assert property (@(posedge linkClk) disable iff (!rstS2_reg)
		lStart |=> !mdioOeN && mdioOut && !mdc ##1 !mdioOeN)
		else $error("frame did not begin with driven preamble");
endmodule

// File: core/pms_pkg.sv
// shared constants and types of the phy management serial controller
package pms_pkg;
	// register byte addresses
	localparam logic [31:0] OFF_REV     = 32'h01c83800;
	localparam logic [31:0] OFF_CTL     = 32'h01c83804;
	localparam logic [31:0] OFF_ALIVE   = 32'h01c83808;
	localparam logic [31:0] OFF_LINK    = 32'h01c8380c;
	localparam logic [31:0] OFF_LRAW    = 32'h01c83810;
	localparam logic [31:0] OFF_LMSK    = 32'h01c83814;
	localparam logic [31:0] OFF_URAW    = 32'h01c83818;
	localparam logic [31:0] OFF_UMSK    = 32'h01c8381c;
	localparam logic [31:0] OFF_MSET    = 32'h01c83820;
	localparam logic [31:0] OFF_MCLR    = 32'h01c83824;
	localparam logic [31:0] OFF_TXN     = 32'h01c83828;
	localparam logic [31:0] OFF_TXN1    = 32'h01c8382c;
	localparam logic [31:0] OFF_SEL     = 32'h01c83830;
	localparam logic [31:0] OFF_SEL1    = 32'h01c83834;
	// field positions
	localparam int          CTL_IDLE    = 31;
	localparam int          CTL_EN      = 30;
	localparam int          TX_GO       = 31;
	localparam int          TX_WR       = 30;
	localparam int          TX_ACK      = 29;
	localparam int          TX_REG_LSB  = 21;
	localparam int          TX_PHY_LSB  = 16;
	localparam int          SEL_LINKEN  = 6;
	localparam int          MAC0        = 0;
	localparam int          SECOND_MAC  = 1;
	// arbitrary revision value
	localparam logic [31:0] REV_VALUE   = 32'h00010000;
	// reset values
	localparam logic        EN_RST      = 1'h0;
	localparam logic        MASK_RST    = 1'h0;
	localparam logic [4:0]  SEL_RST     = 5'h00;
	// frame layout
	localparam logic [4:0]  POLL_REG    = 5'h01;
	localparam int          LINK_BIT    = 2;
	localparam logic [5:0]  TA_BIT      = 6'h2e;
	localparam logic [5:0]  ACK_BIT     = 6'h2f;
	localparam logic [5:0]  DATA_BIT    = 6'h30;
	localparam logic [5:0]  LAST_BIT    = 6'h3f;
	// timing: half of the least management clock period
	localparam int          LINK_NS     = 80;
	localparam int          MDC_HALF_NS = 200;
	localparam int          MDC_HALF_CYC = (MDC_HALF_NS + LINK_NS - 1) / LINK_NS;
	typedef enum logic {L_IDLE, L_SHIFT} pms_lstate_t;
endpackage

// File: verification/pms_phy_model.sv
// behavioural phy on the shared management line, answering at one address
`timescale 1ns/1ps
module pms_phy_model #(
	parameter logic [4:0] ADDR = 5'h05
) (
	input  wire logic mdc,    // management clock from the controller
	input  wire logic mdio,   // resolved data line
	input  wire logic linkUp, // link state shown in status bit 2
	output logic      oe,     // high while this phy drives the line
	output logic      val     // level driven
);
	logic [15:0] regs[32];
	logic [12:0] hdr;
	logic [15:0] sh;
	logic        hit;
	int          ones = 0;
	int          pos = 0;
	initial begin
		oe = 1'b0;
		val = 1'b1;
		hit = 1'b0;
		foreach (regs[i]) regs[i] = 16'h0000;
	end
	// sample on rise; the controller launches on the fall
	always @(posedge mdc) begin
		if (pos == 0) begin
			if (mdio) ones++;
			else if (ones >= 32) pos = 33;
			else ones = 0;
		end else begin
			if (pos < 46) hdr = {hdr[11:0], mdio};
			sh = {sh[14:0], mdio};
			pos++;
			if (pos == 46) hit = hdr[12:10] == 3'h6 && hdr[9:5] == ADDR;
			if (pos == 64) begin
				if (hdr[12:10] == 3'h5 && hdr[9:5] == ADDR)
					regs[hdr[4:0]] = sh;
				pos = 0;
				ones = 0;
			end
		end
	end
	// a real phy drives late in the low phase; released line floats high
	always @(negedge mdc) begin
		regs[1][2] = linkUp;
		if (hit && pos == 47) begin
			oe = 1'b1;
			val = 1'b0;
		end else if (hit && pos > 47) val = regs[hdr[4:0]][63 - pos];
		else if (pos == 0) begin
			oe = 1'b0;
			hit = 1'b0;
		end
	end
endmodule

// File: verification/tb_top.sv
// self-checking bench of the phy management serial controller
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errorCnt++; \
	$display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_top;
	import pms_pkg::*;
	localparam logic [4:0] PHY = 5'h05;
	logic        clk = 1'b0, nrst = 1'b0, linkClk = 1'b0;
	logic        wr = 1'b0, rd = 1'b0, linkUp = 1'b0, rdSeen = 1'b0;
	logic [31:0] addr = 32'h0, wdata = 32'h0, rnd = 32'h18;
	logic [31:0] rdata, v, txn, expQ[$], mskQ[$];
	logic        mdc, mdioOut, mdioOeN, linkIrq, userIrq, phyOe, phyVal;
	int          errorCnt = 0, checks = 0;
	// pull-up on the shared data line
	wire         mdio = !mdioOeN ? mdioOut : (phyOe ? phyVal : 1'b1);
	always #25 clk = ~clk;
	initial begin
		#13;
		forever #40 linkClk = ~linkClk;
	end
	pms_core #(.MDC_HALF(2)) i_dut (.clk(clk), .nrst(nrst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .linkClk(linkClk),
		.mdc(mdc), .mdioIn(mdio), .mdioOut(mdioOut), .mdioOeN(mdioOeN),
		.linkIrq(linkIrq), .userIrq(userIrq));
	pms_phy_model #(.ADDR(PHY)) i_phy (.mdc(mdc), .mdio(mdio),
		.linkUp(linkUp), .oe(phyOe), .val(phyVal));
	always @(posedge clk) begin : mon
		logic [31:0] m, e;
		if (rdSeen) begin
			m = mskQ.pop_front();
			e = expQ.pop_front();
			`CHK(rdata & m, e & m)
		end
		rdSeen <= rd;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic wreg(input logic [31:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rreg(input logic [31:0] a, e, m, output logic [31:0] q);
		addr <= a;
		rd <= 1'b1;
		expQ.push_back(e);
		mskQ.push_back(m);
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		q = rdata;
	endtask
	task automatic chk(input logic [31:0] a, input logic [31:0] e);
		rreg(a, e, 32'hffffffff, v);
	endtask
	// bounded poll of a register; a mask of zero makes the read a no-op check
	task automatic wait_for(input logic [31:0] a, e, m);
		int n;
		for (n = 0; n < 20000; n++) begin
			rreg(a, 32'h0, 32'h0, v);
			if ((v & m) === e) break;
		end
		if (n == 20000) begin
			errorCnt++;
			$display("ERROR %0t: wait expired", $time);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, errorCnt);
		if (errorCnt == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		// link side resets through a synchroniser, so hold longer
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		chk(OFF_REV, REV_VALUE);
		chk(OFF_CTL, 32'h80000000);
		chk(OFF_URAW, 32'h0);
		chk(OFF_LRAW, 32'h0);
		chk(OFF_MSET, 32'h0);
		chk(OFF_SEL, 32'h0);
		// spares TXN1 and SEL1 are only read; an undecoded address is written, then read back as zero
		chk(OFF_TXN1, 32'h0);
		chk(OFF_SEL1, 32'h0);
		wreg(32'h01c83838, 32'hffffffff);
		chk(32'h01c83838, 32'h0);
		// user write, then a second start while pending must be ignored
		rnd = xs(rnd);
		txn = {3'h6, 3'h0, 5'h04 + {2'h0, rnd[18:16]}, PHY, rnd[15:0]};
		wreg(OFF_TXN, txn);
		wreg(OFF_TXN, 32'h80000000);
		rreg(OFF_TXN, 32'h80000000, 32'h80000000, v);
		chk(OFF_CTL, 32'h0);
		wait_for(OFF_CTL, 32'h80000000, 32'h80000000);
		chk(OFF_TXN, (txn & 32'h7fffffff) | 32'h20000000);
		chk(OFF_URAW, 32'h1);
		`CHK(userIrq, 1'b0)
		wreg(OFF_MSET, 32'h1);
		`CHK(userIrq, 1'b1)
		chk(OFF_UMSK, 32'h1);
		chk(OFF_MCLR, 32'h1);
		wreg(OFF_UMSK, 32'h1);
		chk(OFF_URAW, 32'h0);
		`CHK(userIrq, 1'b0)
		// read back what was written, then a read of an absent address
		wreg(OFF_TXN, {3'h4, 3'h0, txn[25:21], PHY, 16'h0});
		wait_for(OFF_CTL, 32'h80000000, 32'h80000000);
		chk(OFF_TXN, {3'h1, 3'h0, txn[25:21], PHY, txn[15:0]});
		`CHK(userIrq, 1'b1)
		wreg(OFF_MCLR, 32'h1);
		`CHK(userIrq, 1'b0)
		wreg(OFF_TXN, {3'h4, 3'h0, 5'h02, PHY + 5'h01, 16'h0});
		wait_for(OFF_CTL, 32'h80000000, 32'h80000000);
		chk(OFF_TXN, {3'h0, 3'h0, 5'h02, PHY + 5'h01, 16'hffff});
		wreg(OFF_URAW, 32'h1);
		// polling with the present phy selected for link changes
		linkUp <= 1'b1;
		wreg(OFF_SEL, {25'h0, 2'h2, PHY});
		chk(OFF_SEL, {25'h0, 2'h2, PHY});
		wreg(OFF_CTL, 32'h40000000);
		wait_for(OFF_LINK, 32'h1 << PHY, 32'hffffffff);
		chk(OFF_ALIVE, 32'h1 << PHY);
		chk(OFF_LRAW, 32'h1);
		chk(OFF_LMSK, 32'h1);
		`CHK(linkIrq, 1'b1)
		// a user read slips in between polls
		wreg(OFF_TXN, {3'h4, 3'h0, txn[25:21], PHY, 16'h0});
		wait_for(OFF_CTL, 32'hc0000000, 32'hc0000000);
		chk(OFF_TXN, {3'h1, 3'h0, txn[25:21], PHY, txn[15:0]});
		wreg(OFF_LRAW, 32'h1);
		chk(OFF_LRAW, 32'h0);
		`CHK(linkIrq, 1'b0)
		linkUp <= 1'b0;
		wait_for(OFF_LINK, 32'h0, 32'hffffffff);
		chk(OFF_LRAW, 32'h1);
		wreg(OFF_LMSK, 32'h1);
		chk(OFF_LRAW, 32'h0);
		// without the enable bit a link change stays unflagged
		wreg(OFF_SEL, {27'h0, PHY});
		linkUp <= 1'b1;
		wait_for(OFF_LINK, 32'h1 << PHY, 32'hffffffff);
		chk(OFF_LRAW, 32'h0);
		`CHK(linkIrq, 1'b0)
		wreg(OFF_CTL, 32'h0);
		report_and_stop;
	end
	initial begin
		#3000000;
		errorCnt++;
		$display("ERROR %0t: run did not finish", $time);
		report_and_stop;
	end
endmodule
